// file: verilog/pic_pkg.sv
package pic_pkg;

  // ****************************************
  // Timing
  // ****************************************
  // Edge detection blanking after an edge-select change, in cycles
  localparam int unsigned NMI_BLANK_CYC = 20;
  localparam int unsigned BLANK_W       = 5;

  // ****************************************
  // Register indices and APB byte addresses
  // ****************************************
  localparam int unsigned APB_AW   = 12;
  localparam logic [31:0] IDX_ICR  = 32'hFFFFFEE0;
  localparam logic [31:0] IDX_PRIORITY_REG_A = 32'hFFFFFEE2;
  localparam logic [31:0] IDX_PRIORITY_REG_B = 32'hFFFFFEE4;
  localparam logic [31:0] IDX_STAT = 32'hFFFFFEE6;
  localparam logic [11:0] ADDR_ICR  = {IDX_ICR[9:0], 2'b00};
  localparam logic [11:0] ADDR_PRIORITY_REG_A = {IDX_PRIORITY_REG_A[9:0], 2'b00};
  localparam logic [11:0] ADDR_PRIORITY_REG_B = {IDX_PRIORITY_REG_B[9:0], 2'b00};
  localparam logic [11:0] ADDR_STAT = {IDX_STAT[9:0], 2'b00};

  // ****************************************
  // Fields and reset values
  // ****************************************
  localparam int unsigned ICR_LVL_BIT  = 15;
  localparam int unsigned ICR_EDGE_BIT = 8;
  localparam int unsigned STAT_NMI_BIT = 16;
  localparam int unsigned F_HI = 12;
  localparam int unsigned F_MH = 8;
  localparam int unsigned F_ML = 4;
  localparam int unsigned F_LO = 0;
  localparam logic [15:0] IPR_RST     = 16'h0000;
  localparam logic [15:0] PRIORITY_REG_B_RDMASK = 16'hFFF0;
  localparam logic        EDGE_RST    = 1'b0;
  localparam logic [3:0]  IRL_IDLE    = 4'hF;

  // ****************************************
  // Levels and cause codes
  // ****************************************
  localparam logic [4:0]  LVL_NMI  = 5'h10;
  localparam logic [4:0]  LVL_OFF  = 5'h00;
  localparam logic [4:0]  LVL_IRLT = 5'h0F;
  localparam logic [11:0] C_NMI    = 12'h1C0;
  localparam logic [11:0] C_IRL    = 12'h200;
  localparam logic [11:0] C_STEP   = 12'h020;
  localparam logic [11:0] C_T0U    = 12'h400;
  localparam logic [11:0] C_T1U    = 12'h420;
  localparam logic [11:0] C_T2U    = 12'h440;
  localparam logic [11:0] C_T2C    = 12'h460;
  localparam logic [11:0] C_CALM   = 12'h480;
  localparam logic [11:0] C_CPER   = 12'h4A0;
  localparam logic [11:0] C_CCRY   = 12'h4C0;
  localparam logic [11:0] C_URE    = 12'h4E0;
  localparam logic [11:0] C_URF    = 12'h500;
  localparam logic [11:0] C_UTE    = 12'h520;
  localparam logic [11:0] C_UTD    = 12'h540;
  localparam logic [11:0] C_WDT    = 12'h560;
  localparam logic [11:0] C_RCM    = 12'h580;
  localparam logic [11:0] C_ROV    = 12'h5A0;
  localparam int unsigned NCAND    = 16;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic tmr0_unf;
    logic tmr1_unf;
    logic tmr2_unf;
    logic tmr2_cap;
    logic clk_alarm;
    logic clk_per;
    logic clk_carry;
    logic uart_rx_err;
    logic uart_rx_full;
    logic uart_tx_empty;
    logic uart_tx_end;
    logic wdt_int;
    logic ref_cmp;
    logic ref_ovf;
  } pic_periph_t;

  typedef struct packed {
    logic [4:0]  level;
    logic [11:0] code;
    logic        is_nmi;
  } pic_cand_t;

endpackage

// file: verilog/pic_filt.sv
`timescale 1ns/100ps
module pic_filt #(
  parameter int unsigned W       = 4,
  parameter logic [W-1:0] RST_VAL = '1
) (
  // Clock and reset
  input  wire logic         i_ref_clk,
  input  wire logic         i_rst_n,
  // Sample strobe and raw pins
  input  wire logic         i_en,
  input  wire logic [W-1:0] i_d,
  // Filtered value
  output logic      [W-1:0] o_q
);

  // ****************************************
  // Synchroniser and two-sample filter
  // ****************************************
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] samp_r;
  logic [W-1:0] q_r;
  logic [W-1:0] samp_nxt;
  logic [W-1:0] q_nxt;

  // Take a new value only after two equal samples
  always_comb begin
    samp_nxt = samp_r;
    q_nxt    = q_r;
    if (i_en) begin
      samp_nxt = s2_r;
      if (s2_r == samp_r) begin
        q_nxt = s2_r;
      end
    end
  end

  // Registers
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      s1_r   <= RST_VAL;
      s2_r   <= RST_VAL;
      samp_r <= RST_VAL;
      q_r    <= RST_VAL;
    end else begin
      s1_r   <= i_d;
      s2_r   <= s1_r;
      samp_r <= samp_nxt;
      q_r    <= q_nxt;
    end
  end

  assign o_q = q_r;

endmodule

// file: verilog/pic_ctrl.sv
// Functional notes
// RQ1: Levels 0..16; level 0 is ignored
// RQ2: NMI level 16, held off by hold flag
// RQ3: Sleep or standby accepts NMI despite hold
// RQ4: NMI edge chosen by edge-select bit 8
// RQ5: Edge-select change clears flag, 20-cycle blank
// RQ6: Controller never writes the CPU mask
// RQ7: Pin level is 15 minus pin code
// RQ8: Pin code taken after two equal samples
// RQ9: Standby samples pins on RTC oscillator
// RQ10: Outside logic keeps pin level until accepted
// RQ11: Priority fields map peripheral groups
// RQ12: Field 0 masks, 1..F give levels
// RQ13: NMI and pin cause codes
// RQ14: Timer cause codes and in-group order
// RQ15: Clock unit and watchdog cause codes
// RQ16: Serial cause codes and in-group order
// RQ17: Refresh cause codes and in-group order
// RQ18: Equal levels follow fixed default order
// RQ19: Priority registers reset to zero, reserved zero
// RQ20: Bit 15 shows NMI pin, read-only
// RQ21: Software edits priorities only while held
// RQ22: Edge select 0 falling, 1 rising
// RQ23: Forward only above CPU mask level
// RQ24: Notify low while unmasked request pends
// RQ25: Registered level and code, stable on accept
//
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/100ps
module pic_ctrl (
  // Clock and reset
  input  wire logic               i_ref_clk,
  input  wire logic               i_rst_n,
  // APB slave
  input  wire logic               i_psel,
  input  wire logic               i_penable,
  input  wire logic               i_pwrite,
  input  wire logic [11:0]        i_paddr,
  input  wire logic [31:0]        i_pwdata,
  output logic      [31:0]        o_prdata,
  output logic                    o_pready,
  output logic                    o_pslverr,
  // Pins
  input  wire logic               i_nmi_pin,
  input  wire logic [3:0]         i_level_request_pins_n,
  input  wire logic               i_rtc_osc,
  output logic                    o_interrupt_notify_out_n,
  // Power state
  input  wire logic               i_sleep,
  input  wire logic               i_standby,
  // Peripheral requests
  input  wire pic_pkg::pic_periph_t i_periph,
  // CPU side
  input  wire logic               i_interrupt_hold_flag,
  input  wire logic [3:0]         i_cpu_mask_level,
  input  wire logic               i_cpu_accept,
  output logic                    o_cpu_req,
  output logic      [4:0]         o_cpu_level,
  output logic      [11:0]        o_cpu_code,
  output logic      [11:0]        o_event_code
);

  // ****************************************
  // Declarations
  // ****************************************
  logic [15:0] prio_a_r;
  logic [15:0] prio_a_nxt;
  logic [15:0] prio_b_r;
  logic [15:0] prio_b_nxt;
  logic        edge_sel_r;
  logic        edge_sel_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic        pready_r;
  logic        pready_nxt;
  logic        pslverr_r;
  logic        pslverr_nxt;
  logic        nmi_s1_r;
  logic        nmi_s2_r;
  logic        nmi_d_r;
  logic        nmi_flag_r;
  logic        nmi_flag_nxt;
  logic [4:0]  blank_r;
  logic [4:0]  blank_nxt;
  logic        req_r;
  logic        req_nxt;
  logic [4:0]  lvl_r;
  logic [4:0]  lvl_nxt;
  logic [11:0] code_r;
  logic [11:0] code_nxt;
  logic        win_nmi_r;
  logic        win_nmi_nxt;
  logic [11:0] evt_r;
  logic [11:0] evt_nxt;
  logic        notify_n_r;
  logic        notify_n_nxt;
  logic [3:0]  irl_code;
  logic        rtc_lvl;
  logic        rtc_d_r;
  logic        irl_en;
  logic        setup;
  logic        wr_en;
  logic        hit;
  logic [31:0] rdata;
  logic        edge_det;
  logic        edge_chg;
  logic        accepted;
  logic        above_mask;
  logic        forward;
  pic_pkg::pic_cand_t cand [pic_pkg::NCAND];
  pic_pkg::pic_cand_t best;
  localparam int unsigned BLANK_W = pic_pkg::BLANK_W;

  // ****************************************
  // Pin conditioning
  // ****************************************
  // RTC oscillator brought into this domain
  pic_filt #(
    .W       (1),
    .RST_VAL (1'b0)
  ) u_rtc_filt (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_en      (1'b1),
    .i_d       (i_rtc_osc),
    .o_q       (rtc_lvl)
  );

  // Pin sampling strobe: RTC rising edges in standby
  assign irl_en = i_standby ? (rtc_lvl & ~rtc_d_r) : 1'b1; // RQ9

  // Level pins, idle code after reset
  pic_filt #(
    .W       (4),
    .RST_VAL (pic_pkg::IRL_IDLE)
  ) u_irl_filt (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_en      (irl_en),
    .i_d       (i_level_request_pins_n),
    .o_q       (irl_code)
  ); // RQ8

  // ****************************************
  // APB slave
  // ****************************************
  // Decode and read mux
  always_comb begin
    hit   = 1'b1;
    rdata = 32'h00000000;
    unique case (i_paddr)
      pic_pkg::ADDR_ICR: begin
        rdata[pic_pkg::ICR_LVL_BIT]  = nmi_s2_r; // RQ20
        rdata[pic_pkg::ICR_EDGE_BIT] = edge_sel_r;
      end
      pic_pkg::ADDR_PRIORITY_REG_A: begin
        rdata[15:0] = prio_a_r;
      end
      pic_pkg::ADDR_PRIORITY_REG_B: begin
        rdata[15:0] = prio_b_r & pic_pkg::PRIORITY_REG_B_RDMASK; // RQ19
      end
      pic_pkg::ADDR_STAT: begin
        rdata[11:0] = evt_r;
        rdata[pic_pkg::STAT_NMI_BIT] = nmi_flag_r;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  // Answer one cycle after setup, no wait states
  assign setup       = i_psel & ~i_penable;
  assign wr_en       = i_psel & i_penable & i_pwrite & pready_r;
  assign pready_nxt  = setup;
  assign pslverr_nxt = setup & ~hit;
  assign prdata_nxt  = setup ? rdata : 32'h00000000;

  // Register writes; pin-level bit ignores writes
  always_comb begin
    prio_a_nxt   = prio_a_r;
    prio_b_nxt   = prio_b_r;
    edge_sel_nxt = edge_sel_r;
    if (wr_en) begin
      unique case (i_paddr)
        pic_pkg::ADDR_ICR: begin
          edge_sel_nxt = i_pwdata[pic_pkg::ICR_EDGE_BIT]; // RQ4
        end
        pic_pkg::ADDR_PRIORITY_REG_A: begin
          prio_a_nxt = i_pwdata[15:0];
        end
        pic_pkg::ADDR_PRIORITY_REG_B: begin
          prio_b_nxt = i_pwdata[15:0] & pic_pkg::PRIORITY_REG_B_RDMASK;
        end
        default: begin
          prio_a_nxt = prio_a_r;
        end
      endcase
    end
  end

  assign edge_chg = edge_sel_nxt != edge_sel_r;

  // ****************************************
  // NMI edge detection
  // ****************************************
  // Falling edge when select is 0, rising when 1
  always_comb begin
    if (edge_sel_r) begin
      edge_det = nmi_s2_r & ~nmi_d_r; // RQ22
    end else begin
      edge_det = ~nmi_s2_r & nmi_d_r; // RQ22
    end
  end

  // Detection flag with blanking; new edge beats accept clear
  always_comb begin
    blank_nxt    = blank_r;
    nmi_flag_nxt = nmi_flag_r;
    if (blank_r != 5'h00) begin
      blank_nxt = blank_r - 5'h01;
    end
    if (edge_chg) begin
      nmi_flag_nxt = 1'b0; // RQ5
      blank_nxt    = BLANK_W'(pic_pkg::NMI_BLANK_CYC); // RQ5
    end else if (edge_det && blank_r == 5'h00) begin
      nmi_flag_nxt = 1'b1; // RQ4
    end else if (accepted && win_nmi_r) begin
      nmi_flag_nxt = 1'b0;
    end
  end

  // ****************************************
  // Candidate table in default order
  // ****************************************
  // Field value is the level; zero masks the group
  function automatic pic_pkg::pic_cand_t mk(input logic       req,
                                            input logic [3:0] fld,
                                            input logic [11:0] code);
    mk.level  = req ? {1'b0, fld} : pic_pkg::LVL_OFF; // RQ12
    mk.code   = code;
    mk.is_nmi = 1'b0;
  endfunction

  always_comb begin
    cand[0].level  = nmi_flag_r ? pic_pkg::LVL_NMI : pic_pkg::LVL_OFF; // RQ2
    cand[0].code   = pic_pkg::C_NMI; // RQ13
    cand[0].is_nmi = 1'b1;
    cand[1].level  = pic_pkg::LVL_IRLT - {1'b0, irl_code}; // RQ7
    cand[1].code   = pic_pkg::C_IRL + 12'(irl_code) * pic_pkg::C_STEP; // RQ13
    cand[1].is_nmi = 1'b0;
    // RQ11
    cand[2]  = mk(i_periph.tmr0_unf, prio_a_r[pic_pkg::F_HI +: 4], pic_pkg::C_T0U); // RQ14
    cand[3]  = mk(i_periph.tmr1_unf, prio_a_r[pic_pkg::F_MH +: 4], pic_pkg::C_T1U); // RQ14
    cand[4]  = mk(i_periph.tmr2_unf, prio_a_r[pic_pkg::F_ML +: 4], pic_pkg::C_T2U); // RQ14
    cand[5]  = mk(i_periph.tmr2_cap, prio_a_r[pic_pkg::F_ML +: 4], pic_pkg::C_T2C); // RQ14
    cand[6]  = mk(i_periph.clk_alarm, prio_a_r[pic_pkg::F_LO +: 4], pic_pkg::C_CALM); // RQ15
    cand[7]  = mk(i_periph.clk_per, prio_a_r[pic_pkg::F_LO +: 4], pic_pkg::C_CPER); // RQ15
    cand[8]  = mk(i_periph.clk_carry, prio_a_r[pic_pkg::F_LO +: 4], pic_pkg::C_CCRY); // RQ15
    cand[9]  = mk(i_periph.uart_rx_err, prio_b_r[pic_pkg::F_ML +: 4], pic_pkg::C_URE); // RQ16
    cand[10] = mk(i_periph.uart_rx_full, prio_b_r[pic_pkg::F_ML +: 4], pic_pkg::C_URF); // RQ16
    cand[11] = mk(i_periph.uart_tx_empty, prio_b_r[pic_pkg::F_ML +: 4], pic_pkg::C_UTE); // RQ16
    cand[12] = mk(i_periph.uart_tx_end, prio_b_r[pic_pkg::F_ML +: 4], pic_pkg::C_UTD); // RQ16
    cand[13] = mk(i_periph.wdt_int, prio_b_r[pic_pkg::F_HI +: 4], pic_pkg::C_WDT); // RQ15
    cand[14] = mk(i_periph.ref_cmp, prio_b_r[pic_pkg::F_MH +: 4], pic_pkg::C_RCM); // RQ17
    cand[15] = mk(i_periph.ref_ovf, prio_b_r[pic_pkg::F_MH +: 4], pic_pkg::C_ROV); // RQ17
  end

  // ****************************************
  // Arbitration
  // ****************************************
  // Strictly greater wins, so ties keep the earlier entry
  always_comb begin
    best = '0;
    for (int i = 0; i < pic_pkg::NCAND; i++) begin
      if (cand[i].level > best.level) begin
        best = cand[i]; // RQ1 RQ18
      end
    end
  end

  // Mask compare; the CPU mask is only ever read here
  assign above_mask = best.level > {1'b0, i_cpu_mask_level}; // RQ23 RQ6

  // Hold flag blocks all but NMI in sleep or standby
  always_comb begin
    if (best.is_nmi) begin
      forward = above_mask & (~i_interrupt_hold_flag | i_sleep | i_standby); // RQ2 RQ3
    end else begin
      forward = above_mask & ~i_interrupt_hold_flag; // RQ23
    end
  end

  // ****************************************
  // CPU request outputs
  // ****************************************
  assign accepted = i_cpu_accept & req_r;

  // Request, level and code follow every cycle; on accept level and code hold, request drops
  always_comb begin
    req_nxt     = req_r;
    lvl_nxt     = lvl_r;
    code_nxt    = code_r;
    win_nmi_nxt = win_nmi_r;
    evt_nxt     = evt_r;
    if (accepted) begin
      evt_nxt = code_r; // RQ13
      req_nxt = 1'b0;
    end else begin
      req_nxt     = forward; // RQ25
      lvl_nxt     = best.level; // RQ25
      code_nxt    = best.code; // RQ25
      win_nmi_nxt = best.is_nmi;
    end
  end

  // Notify ignores the hold flag
  assign notify_n_nxt = ~above_mask; // RQ24

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      prio_a_r   <= pic_pkg::IPR_RST; // RQ19
      prio_b_r   <= pic_pkg::IPR_RST; // RQ19
      edge_sel_r <= pic_pkg::EDGE_RST; // RQ22
      prdata_r   <= 32'h00000000;
      pready_r   <= 1'b0;
      pslverr_r  <= 1'b0;
      nmi_s1_r   <= 1'b0;
      nmi_s2_r   <= 1'b0;
      nmi_d_r    <= 1'b0;
      nmi_flag_r <= 1'b0;
      blank_r    <= 5'h00;
      rtc_d_r    <= 1'b0;
      req_r      <= 1'b0;
      lvl_r      <= 5'h00;
      code_r     <= 12'h000;
      win_nmi_r  <= 1'b0;
      evt_r      <= 12'h000;
      notify_n_r <= 1'b1;
    end else begin
      prio_a_r   <= prio_a_nxt;
      prio_b_r   <= prio_b_nxt;
      edge_sel_r <= edge_sel_nxt;
      prdata_r   <= prdata_nxt;
      pready_r   <= pready_nxt;
      pslverr_r  <= pslverr_nxt;
      nmi_s1_r   <= i_nmi_pin;
      nmi_s2_r   <= nmi_s1_r;
      nmi_d_r    <= nmi_s2_r;
      nmi_flag_r <= nmi_flag_nxt;
      blank_r    <= blank_nxt;
      rtc_d_r    <= rtc_lvl;
      req_r      <= req_nxt;
      lvl_r      <= lvl_nxt;
      code_r     <= code_nxt;
      win_nmi_r  <= win_nmi_nxt;
      evt_r      <= evt_nxt;
      notify_n_r <= notify_n_nxt;
    end
  end

  // Outputs straight from flops
  assign o_prdata                 = prdata_r;
  assign o_pready                 = pready_r;
  assign o_pslverr                = pslverr_r;
  assign o_interrupt_notify_out_n = notify_n_r;
  assign o_cpu_req                = req_r;
  assign o_cpu_level              = lvl_r;
  assign o_cpu_code               = code_r;
  assign o_event_code             = evt_r;

endmodule

// file: bench/pic_ctrl_props.sv
`timescale 1ns/100ps
// ****************************************
// Checker on the CPU request outputs
// ****************************************
module pic_ctrl_props (
  // Clock and reset
  input wire logic        i_ref_clk,
  input wire logic        i_rst_n,
  // CPU side and power state
  input wire logic        i_interrupt_hold_flag,
  input wire logic        i_sleep,
  input wire logic        i_standby,
  input wire logic [3:0]  i_cpu_mask_level,
  input wire logic        i_cpu_accept,
  // Outputs under watch
  input wire logic        o_cpu_req,
  input wire logic [4:0]  o_cpu_level,
  input wire logic [11:0] o_cpu_code,
  input wire logic [11:0] o_event_code,
  input wire logic        o_interrupt_notify_out_n
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  // Level, code and handshake relations
  live_level_a: assert property (o_cpu_req |-> o_cpu_level != 5'h00)
    else $error("request forwarded at level zero");
  above_mask_a: assert property (o_cpu_req |-> o_cpu_level > {1'h0, $past(i_cpu_mask_level)})
    else $error("request forwarded at or below the mask");
  nmi_code_a: assert property (o_cpu_req && o_cpu_level == 5'h10 |-> o_cpu_code == 12'h1C0)
    else $error("top level request without the NMI code");
  pin_code_a: assert property (o_cpu_req && o_cpu_code > 12'h1C0 && o_cpu_code < 12'h400
    |-> o_cpu_code == 12'h3E0 - {3'h0, o_cpu_level[3:0], 5'h00})
    else $error("pin code does not match pin level");
  hold_off_a: assert property ($past(i_interrupt_hold_flag) && !$past(i_sleep)
    && !$past(i_standby) |-> !o_cpu_req)
    else $error("request forwarded under hold");
  event_latch_a: assert property (o_cpu_req && i_cpu_accept |=> o_event_code == $past(o_cpu_code))
    else $error("event code differs from accepted code");
  req_drop_a: assert property (o_cpu_req && i_cpu_accept |=> !o_cpu_req ##1 $stable(o_event_code))
    else $error("request not withdrawn after acceptance");
  notify_low_a: assert property (o_cpu_req |-> !o_interrupt_notify_out_n)
    else $error("notify high while a request is forwarded");
endmodule

bind pic_ctrl pic_ctrl_props u_props (.i_ref_clk, .i_rst_n, .i_interrupt_hold_flag, .i_sleep,
  .i_standby, .i_cpu_mask_level, .i_cpu_accept, .o_cpu_req, .o_cpu_level, .o_cpu_code,
  .o_event_code, .o_interrupt_notify_out_n);

// file: bench/pic_cpu_model.sv
`timescale 1ns/100ps
// ****************************************
// CPU core accepting forwarded requests
// ****************************************
module pic_cpu_model (
  // Clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst_n,
  // Bench control: enable and accept delay
  input  wire logic       i_en,
  input  wire logic [3:0] i_wait,
  // Request from the controller
  input  wire logic       i_cpu_req,
  output logic            o_cpu_accept = 1'h0
);
  logic [3:0] cnt_r = 4'h0;

  // One accept pulse per request, after a settable delay
  always @(posedge i_ref_clk) begin
    if (!i_rst_n || o_cpu_accept || !i_cpu_req || !i_en) begin
      o_cpu_accept <= 1'h0;
      cnt_r        <= 4'h0;
    end else if (cnt_r >= i_wait) begin
      o_cpu_accept <= 1'h1;
    end else begin
      cnt_r <= cnt_r + 4'h1;
    end
  end
endmodule

// file: bench/priority_interrupt_controller_test.sv
`timescale 1ns/100ps
module priority_interrupt_controller_test;
  logic        clk     = 1'h0;
  logic        rst_n   = 1'h0;
  logic        psel    = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite  = 1'h0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        nmi     = 1'h1;
  logic [3:0]  pins_n  = 4'hF;
  logic        sleep   = 1'h0;
  logic        standby = 1'h0;
  logic        rtc     = 1'h0;
  logic        rtc_on  = 1'h0;
  logic        hold    = 1'h1;
  logic [3:0]  mask    = 4'h0;
  logic        en      = 1'h0;
  logic [3:0]  wait_c  = 4'h0;
  logic        accept;
  logic        notify_n;
  logic        req;
  logic [4:0]  lvl;
  logic [11:0] code;
  logic [11:0] evt;
  logic [31:0] rd;
  logic        err;
  int          miscompares = 0;
  int          tests_run   = 0;
  int          cycles      = 0;
  pic_pkg::pic_periph_t periph = '0;
  localparam logic [11:0] CODES [14] = '{12'h400, 12'h420, 12'h440, 12'h460, 12'h480,
    12'h4A0, 12'h4C0, 12'h4E0, 12'h500, 12'h520, 12'h540, 12'h560, 12'h580, 12'h5A0};
  localparam logic [13:0] TIE_P [9] = '{14'h3FFF, 14'h0C00, 14'h0380, 14'h0180, 14'h0078,
    14'h0038, 14'h0018, 14'h0044, 14'h0007};
  localparam logic [11:0] TIE_C [9] = '{12'h400, 12'h440, 12'h480, 12'h4A0, 12'h4E0,
    12'h500, 12'h520, 12'h4E0, 12'h560};

  // ****************************************
  // Design, CPU model and clock
  // ****************************************
  pic_ctrl uut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_nmi_pin(nmi), .i_level_request_pins_n(pins_n),
    .i_rtc_osc(rtc), .o_interrupt_notify_out_n(notify_n), .i_sleep(sleep),
    .i_standby(standby), .i_periph(periph), .i_interrupt_hold_flag(hold),
    .i_cpu_mask_level(mask), .i_cpu_accept(accept), .o_cpu_req(req), .o_cpu_level(lvl),
    .o_cpu_code(code), .o_event_code(evt));
  pic_cpu_model u_cpu (.i_ref_clk(clk), .i_rst_n(rst_n), .i_en(en), .i_wait(wait_c),
    .i_cpu_req(req), .o_cpu_accept(accept));

  // Free running clock
  always #50 clk = ~clk;

  // Hang guard and slow oscillator, one rise every eight cycles when on
  always @(posedge clk) begin
    cycles <= cycles + 1;
    rtc    <= cycles[2] & rtc_on;
    if (cycles == 20000) begin
      miscompares++;
      end_sim();
    end
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One bus transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'h1;
    do begin
      @(posedge clk);
    end while (pready !== 1'h1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0);
    check(name, rd, exp);
  endtask

  // Raise sources, expect a request or none, let the CPU accept it
  task automatic serve(input logic nm, input logic [3:0] pins, input logic [13:0] per,
                       input logic [4:0] lvl_e, input logic [11:0] code_e);
    @(posedge clk);
    nmi    <= nm;
    pins_n <= pins;
    periph <= per;
    for (int n = 0; n < 30 && req !== 1'h1; n++) @(negedge clk);
    check("req", {31'h0, req}, {31'h0, lvl_e != 5'h00});
    if (lvl_e != 5'h00) begin
      check("level", {27'h0, lvl}, {27'h0, lvl_e});
      check("code", {20'h0, code}, {20'h0, code_e});
      @(posedge clk);
      en <= 1'h1;
      for (int n = 0; n < 20 && req === 1'h1; n++) @(negedge clk);
      check("event", {20'h0, evt}, {20'h0, code_e});
      @(posedge clk);
      en     <= 1'h0;
      pins_n <= 4'hF;
      periph <= '0;
    end
    repeat (6) @(posedge clk);
  endtask

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'h1;
    // Let the pin synchroniser fill before the first read
    repeat (2) @(posedge clk);
    rd_chk("icr_rst", pic_pkg::ADDR_ICR, 32'h00008000);
    rd_chk("priority_reg_a_rst", pic_pkg::ADDR_PRIORITY_REG_A, 32'h0);
    rd_chk("priority_reg_b_rst", pic_pkg::ADDR_PRIORITY_REG_B, 32'h0);
    apb(1'h1, pic_pkg::ADDR_PRIORITY_REG_A, 32'hFFFFFFFF);
    rd_chk("priority_reg_a", pic_pkg::ADDR_PRIORITY_REG_A, 32'h0000FFFF);
    apb(1'h1, pic_pkg::ADDR_PRIORITY_REG_B, 32'hFFFFFFFF);
    rd_chk("priority_reg_b", pic_pkg::ADDR_PRIORITY_REG_B, 32'h0000FFF0);
    apb(1'h1, pic_pkg::ADDR_ICR, 32'hFFFFFFFF);
    rd_chk("icr", pic_pkg::ADDR_ICR, 32'h00008100);
    apb(1'h1, pic_pkg::ADDR_ICR, 32'h0);
    rd_chk("icr", pic_pkg::ADDR_ICR, 32'h00008000);
    rd_chk("unmapped", 12'hFFC, 32'h0);
    check("pslverr", {31'h0, err}, 32'h1);
    apb(1'h1, pic_pkg::ADDR_PRIORITY_REG_A, 32'h5555);
    apb(1'h1, pic_pkg::ADDR_PRIORITY_REG_B, 32'h5550);
    rd_chk("priority_reg_b", pic_pkg::ADDR_PRIORITY_REG_B, 32'h5550);
    repeat (25) @(posedge clk);
    hold <= 1'h0;
    for (int i = 0; i < 14; i++) serve(1'h1, 4'hF, 14'h2000 >> i, 5'h05, CODES[i]);
    for (int i = 0; i < 9; i++) serve(1'h1, 4'hF, TIE_P[i], 5'h05, TIE_C[i]);
    hold <= 1'h1;
    apb(1'h1, pic_pkg::ADDR_PRIORITY_REG_B, 32'hF550);
    rd_chk("priority_reg_b", pic_pkg::ADDR_PRIORITY_REG_B, 32'hF550);
    hold <= 1'h0;
    serve(1'h1, 4'hF, 14'h3FFF, 5'h0F, 12'h560);
    // Pins settle through their filter before the peripheral tie joins
    pins_n <= 4'h0;
    repeat (6) @(posedge clk);
    serve(1'h1, 4'h0, 14'h0004, 5'h0F, 12'h200);
    wait_c <= 4'h5;
    for (int c = 0; c < 15; c++) serve(1'h1, c[3:0], '0, 5'(15 - c), 12'h200 + 12'(c * 32));
    mask <= 4'h3;
    serve(1'h1, 4'hC, '0, 5'h00, 12'h000);
    mask <= 4'h2;
    serve(1'h1, 4'hC, '0, 5'h03, 12'h380);
    mask <= 4'h0;
    hold <= 1'h1;
    apb(1'h1, pic_pkg::ADDR_PRIORITY_REG_A, 32'h0);
    hold <= 1'h0;
    serve(1'h1, 4'hF, 14'h2000, 5'h00, 12'h000);
    wait_c <= 4'h0;
    serve(1'h0, 4'hF, '0, 5'h10, 12'h1C0);
    serve(1'h1, 4'hF, '0, 5'h00, 12'h000);
    hold <= 1'h1;
    serve(1'h0, 4'hF, '0, 5'h00, 12'h000);
    rd_chk("stat", pic_pkg::ADDR_STAT, 32'h000101C0);
    check("notify", {31'h0, notify_n}, 32'h0);
    sleep <= 1'h1;
    serve(1'h0, 4'hF, '0, 5'h10, 12'h1C0);
    sleep <= 1'h0;
    hold  <= 1'h0;
    apb(1'h1, pic_pkg::ADDR_ICR, 32'h0100);
    repeat (25) @(posedge clk);
    serve(1'h1, 4'hF, '0, 5'h10, 12'h1C0);
    hold <= 1'h1;
    serve(1'h0, 4'hF, '0, 5'h00, 12'h000);
    serve(1'h1, 4'hF, '0, 5'h00, 12'h000);
    apb(1'h1, pic_pkg::ADDR_ICR, 32'h0);
    hold <= 1'h0;
    serve(1'h1, 4'hF, '0, 5'h00, 12'h000);
    // Standby: pins are sampled only on rising oscillator edges
    standby <= 1'h1;
    serve(1'h1, 4'hC, '0, 5'h00, 12'h000);
    rtc_on <= 1'h1;
    serve(1'h1, 4'hC, '0, 5'h03, 12'h380);
    standby <= 1'h0;
    end_sim();
  end
endmodule
